// >>> design/csic_core.sv
`timescale 1ns/1ps
// Summary of operation
// - six top registers form three pointers
// - pointers use displacement, postincrement or predecrement
// - push lowers pointer one, call/interrupt two
// - pop raises pointer one, return two
// - stack pointer two bytes, high reads zero
// - one undivided clock, fetch overlaps execute
// - take only when source and global enabled
// - lower vector ranks higher, reset first
// - taking interrupt clears global enable
// - interrupt return sets global enable
// - vectoring or writing one clears flag
// - disabled flag stays pending until served
// - pending flags served in priority order
// - level sources request only while present
// - one instruction runs after interrupt return
// - flags register never saved by hardware
// - disable acts at once, same cycle too
// - instruction after enable runs before interrupts
// - entry four cycles, pushes program counter
// - wake from sleep adds four cycles
// - return four cycles, pops counter, enables
// - global enable is flags bit seven
module csic_core (
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic                           instr_done,
    input  wire logic                           op_push,
    input  wire logic                           op_pop,
    input  wire logic                           op_call,
    input  wire logic                           op_ret,
    input  wire logic                           op_interrupt_return_instruction,
    input  wire logic                           op_sei,
    input  wire logic                           op_cli,
    input  wire logic [9:0]                     pc_in,
    input  wire logic                           sleeping,
    input  wire logic                           wake_ready,
    input  wire logic                           alu_flags_wr,
    input  wire logic [6:0]                     alu_flags,
    input  wire logic                           io_wr_en,
    input  wire logic                           io_rd_en,
    input  wire logic [5:0]                     io_addr,
    input  wire logic [7:0]                     io_wr_data,
    output logic      [7:0]                     io_rd_data,
    input  wire logic                           gpr_wr_en,
    input  wire logic [4:0]                     gpr_wr_addr,
    input  wire logic [7:0]                     gpr_wr_data,
    input  wire logic [4:0]                     gpr_rd_addr,
    output logic      [7:0]                     gpr_rd_data,
    input  wire logic                           ptr_req,
    input  wire logic [1:0]                     ptr_sel,
    input  wire csic_pkg::csic_ptr_e            ptr_mode,
    input  wire logic [5:0]                     ptr_disp,
    output logic      [15:0]                    data_addr,
    input  wire logic [csic_pkg::CSIC_NSRC-1:0] irq_flag_set,
    input  wire logic [csic_pkg::CSIC_NSRC-1:0] irq_level,
    input  wire logic [csic_pkg::CSIC_NSRC-1:0] irq_enable,
    input  wire logic                           flag_clr_wr,
    input  wire logic [csic_pkg::CSIC_NSRC-1:0] flag_clr_data,
    output logic      [csic_pkg::CSIC_NSRC-1:0] irq_ack,
    output logic                                seq_hold,
    output logic                                wake_req,
    output logic                                vector_valid,
    output logic      [9:0]                     vector_addr,
    output logic                                stack_we,
    output logic                                stack_rd_en,
    output logic      [15:0]                    stack_addr,
    output logic      [7:0]                     stack_wr_data,
    input  wire logic [7:0]                     stack_rd_data,
    output logic                                pc_load,
    output logic      [9:0]                     pc_out,
    output logic                                gie
);
    import csic_pkg::*;

    typedef struct packed {
        csic_st_e             st;
        logic [3:0]           cnt;
        logic                 wake;
        logic [7:0]           stack_pointer_low;
        logic [7:0]           processor_flags_register;
        logic                 inhib;
        logic [5:0][7:0]      pb;
        logic [15:0]          data_addr;
        logic [7:0]           gpr_rd;
        logic [7:0]           io_rd;
        logic [CSIC_NSRC-1:0] ack;
        logic                 hold;
        logic                 wake_req;
        logic                 vec_valid;
        logic [9:0]           vec_addr;
        logic [9:0]           ret_pc;
        logic [CSIC_IDXW-1:0] idx;
        logic                 we;
        logic                 rd_en;
        logic [15:0]          saddr;
        logic [7:0]           wd;
        logic                 pc_load;
        logic [9:0]           pc_out;
    } csic_core_s;

    csic_core_s  r;
    csic_core_s  next_r;
    logic        take;
    logic        gate;
    logic [2:0]  pslot;
    logic [15:0] ptr_cur;
    logic [15:0] ptr_new;
    logic [3:0]  last;

    csic_irq_if irq ();

    csic_irq_arb u_arb (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .irq_flag_set (irq_flag_set),
        .irq_level    (irq_level),
        .irq          (irq.arb)
    );

    function automatic logic csic_is_ptr(input logic [4:0] a);
        csic_is_ptr = (a >= CSIC_PTR_BASE) && (a <= CSIC_PTR_TOP);
    endfunction

    function automatic logic [2:0] csic_slot(input logic [4:0] a);
        csic_slot = 3'(a - CSIC_PTR_BASE);
    endfunction

    assign irq.en       = irq_enable;
    assign irq.clr_wr   = flag_clr_wr;
    assign irq.clr_data = flag_clr_data;
    assign irq.ack      = take;
    assign irq.ack_idx  = irq.req_idx;

    always_comb
    begin
        next_r       = r;
        take         = 1'b0;
        pslot        = {ptr_sel, 1'b0};
        ptr_cur      = {r.pb[pslot + 3'h1], r.pb[pslot]};
        ptr_new      = ptr_cur;
        last         = r.wake ? CSIC_WAKE_LAST : CSIC_ENTRY_LAST;
        // global enable, no inhibit, plus a gated request from the arbiter
        gate         = r.processor_flags_register[CSIC_GIE_BIT] && !r.inhib
                     && irq.req_any;
        next_r.ack       = '0;
        next_r.vec_valid = 1'b0;
        next_r.we        = 1'b0;
        next_r.rd_en     = 1'b0;
        next_r.pc_load   = 1'b0;

        // register file bytes behind the pointers
        if (gpr_wr_en && csic_is_ptr(gpr_wr_addr))
        begin
            next_r.pb[csic_slot(gpr_wr_addr)] = gpr_wr_data;
        end
        next_r.gpr_rd = csic_is_ptr(gpr_rd_addr)
                      ? r.pb[csic_slot(gpr_rd_addr)] : 8'h00;

        // indirect address generation
        if (ptr_req)
        begin
            next_r.data_addr = ptr_cur;
            unique case (ptr_mode)
                CSIC_PTR_PLAIN:
                begin
                    next_r.data_addr = ptr_cur;
                end
                CSIC_PTR_DISP:
                begin
                    next_r.data_addr = ptr_cur + {10'h000, ptr_disp};
                end
                CSIC_PTR_POSTINC:
                begin
                    ptr_new = ptr_cur + 16'h0001;
                end
                CSIC_PTR_PREDEC:
                begin
                    ptr_new          = ptr_cur - 16'h0001;
                    next_r.data_addr = ptr_new;
                end
            endcase
            next_r.pb[pslot]        = ptr_new[7:0];
            next_r.pb[pslot + 3'h1] = ptr_new[15:8];
        end

        // flag bits from the alu; bit seven left to control
        if (alu_flags_wr)
        begin
            next_r.processor_flags_register[6:0] = alu_flags;
        end

        // stack pointer steps from the sequencer
        if (r.st == CSIC_IDLE)
        begin
            if (op_push)
            begin
                next_r.stack_pointer_low = r.stack_pointer_low - 8'h01;
            end
            else if (op_call)
            begin
                next_r.stack_pointer_low = r.stack_pointer_low - 8'h02;
            end
            else if (op_pop)
            begin
                next_r.stack_pointer_low = r.stack_pointer_low + 8'h01;
            end
            else if (op_ret)
            begin
                next_r.stack_pointer_low = r.stack_pointer_low + 8'h02;
            end
        end

        // i/o register port
        if (io_rd_en)
        begin
            case (io_addr)
                CSIC_IO_SPL:   next_r.io_rd = r.stack_pointer_low;
                CSIC_IO_SPH:   next_r.io_rd = CSIC_SPH_VALUE;
                CSIC_IO_FLAGS: next_r.io_rd = r.processor_flags_register;
                default:       next_r.io_rd = 8'h00;
            endcase
        end
        if (io_wr_en)
        begin
            if (io_addr == CSIC_IO_SPL)
            begin
                next_r.stack_pointer_low = io_wr_data;
            end
            else if (io_addr == CSIC_IO_FLAGS)
            begin
                next_r.processor_flags_register = io_wr_data;
            end
        end

        next_r.wake_req = sleeping && r.processor_flags_register[CSIC_GIE_BIT]
                        && irq.req_any && (r.st == CSIC_IDLE);

        unique case (r.st)
            CSIC_IDLE:
            begin
                if (instr_done)
                begin
                    // requests sampled at instruction boundaries or on wake from sleep
                    if (op_sei)
                    begin
                        next_r.processor_flags_register[CSIC_GIE_BIT] = 1'b1;
                        next_r.inhib              = 1'b1;
                    end
                    else
                    begin
                        next_r.inhib = 1'b0;
                        if (op_cli)
                        begin
                            next_r.processor_flags_register[CSIC_GIE_BIT] = 1'b0;
                        end
                        else if (gate)
                        begin
                            take = 1'b1;
                        end
                    end
                end
                else if (sleeping && wake_ready && gate)
                begin
                    take = 1'b1;
                end
                else if (op_interrupt_return_instruction)
                begin
                    next_r.st   = CSIC_RETURN;
                    next_r.cnt  = 4'h0;
                    next_r.hold = 1'b1;
                end
                if (take)
                begin
                    next_r.st                 = CSIC_ENTRY;
                    next_r.cnt                = 4'h0;
                    next_r.wake               = sleeping && !instr_done;
                    next_r.processor_flags_register[CSIC_GIE_BIT] = 1'b0;
                    next_r.ret_pc             = pc_in;
                    next_r.idx                = irq.req_idx;
                    next_r.ack = csic_onehot(irq.req_idx);
                    next_r.hold               = 1'b1;
                end
            end
            CSIC_ENTRY:
            begin
                // push low byte then high byte of the return address
                if (r.cnt == 4'h0 || r.cnt == 4'h1)
                begin
                    next_r.we    = 1'b1;
                    next_r.saddr = {8'h00, r.stack_pointer_low};
                    next_r.wd    = (r.cnt == 4'h0) ? r.ret_pc[7:0]
                                 : {6'h00, r.ret_pc[9:8]};
                    next_r.stack_pointer_low   = r.stack_pointer_low - 8'h01;
                end
                if (r.cnt == last)
                begin
                    next_r.st        = CSIC_IDLE;
                    next_r.hold      = 1'b0;
                    next_r.vec_valid = 1'b1;
                    next_r.vec_addr  = CSIC_VEC_BASE
                                     + {8'h00, r.idx};
                end
                else
                begin
                    next_r.cnt = r.cnt + 4'h1;
                end
            end
            CSIC_RETURN:
            begin
                // read data arrives one cycle after the strobe is seen
                if (r.cnt == 4'h0 || r.cnt == 4'h1)
                begin
                    next_r.rd_en = 1'b1;
                    next_r.saddr = {8'h00, r.stack_pointer_low + 8'h01};
                    next_r.stack_pointer_low   = r.stack_pointer_low + 8'h01;
                end
                if (r.cnt == 4'h2)
                begin
                    next_r.pc_out[9:8] = stack_rd_data[1:0];
                end
                if (r.cnt == CSIC_INTERRUPT_RETURN_INSTRUCTION_LAST)
                begin
                    next_r.pc_out[7:0]        = stack_rd_data;
                    next_r.pc_load            = 1'b1;
                    next_r.processor_flags_register[CSIC_GIE_BIT] = 1'b1;
                    next_r.inhib              = 1'b1;
                    next_r.hold               = 1'b0;
                    next_r.st                 = CSIC_IDLE;
                end
                else
                begin
                    next_r.cnt = r.cnt + 4'h1;
                end
            end
            default:
            begin
                next_r.st   = CSIC_IDLE;
                next_r.hold = 1'b0;
            end
        endcase
    end

    // single core clock, no division
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            r          <= '0;
            r.st       <= CSIC_IDLE;
            r.stack_pointer_low      <= CSIC_SPL_RESET;
            r.processor_flags_register     <= CSIC_FLAGS_RESET;
            r.vec_addr <= CSIC_RESET_VEC;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign io_rd_data    = r.io_rd;
    assign gpr_rd_data   = r.gpr_rd;
    assign data_addr     = r.data_addr;
    assign irq_ack       = r.ack;
    assign seq_hold      = r.hold;
    assign wake_req      = r.wake_req;
    assign vector_valid  = r.vec_valid;
    assign vector_addr   = r.vec_addr;
    assign stack_we      = r.we;
    assign stack_rd_en   = r.rd_en;
    assign stack_addr    = r.saddr;
    assign stack_wr_data = r.wd;
    assign pc_load       = r.pc_load;
    assign pc_out        = r.pc_out;
    assign gie           = r.processor_flags_register[CSIC_GIE_BIT];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sp_push_a: assert property ((r.st == CSIC_IDLE && op_push && !take
        && !io_wr_en) |=> r.stack_pointer_low == $past(r.stack_pointer_low) - 8'h01)
        else $error("push did not lower stack pointer by one");

    sp_ret_a: assert property ((r.st == CSIC_IDLE && op_ret && !op_push
        && !op_call && !op_pop && !take && !io_wr_en && !op_interrupt_return_instruction)
        |=> r.stack_pointer_low == $past(r.stack_pointer_low) + 8'h02)
        else $error("return did not raise stack pointer by two");

    sph_zero_a: assert property ((io_rd_en && io_addr == CSIC_IO_SPH)
        |=> io_rd_data == 8'h00)
        else $error("high stack byte read not zero");

    take_gate_a: assert property (take |->
        (gie && (irq.req & irq_enable) != '0 && !r.inhib))
        else $error("interrupt taken while disabled");

    entry_gie_a: assert property (take |=> !gie && seq_hold)
        else $error("global enable not cleared on entry");

    cli_block_a: assert property ((instr_done && op_cli) |-> !take)
        else $error("interrupt taken with disable instruction");

    // helper: last idle boundary carried the enable instruction
    logic sei_last;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sei_last <= 1'b0;
        end
        else if (instr_done && r.st == CSIC_IDLE)
        begin
            sei_last <= op_sei;
        end
    end

    sei_defer_a: assert property (sei_last |-> !take)
        else $error("interrupt served before next instruction");

    entry_len_a: assert property ((take && !sleeping) |=>
        seq_hold[*4] ##1 (!seq_hold && vector_valid))
        else $error("entry latency not four cycles");

    wake_len_a: assert property ((take && sleeping && !instr_done) |=>
        seq_hold[*8] ##1 (!seq_hold && vector_valid))
        else $error("wake entry latency not eight cycles");

    interrupt_return_instruction_len_a: assert property ((r.st == CSIC_IDLE && op_interrupt_return_instruction
        && !instr_done && !(sleeping && wake_ready && gate))
        |=> seq_hold[*4] ##1 (pc_load && gie && r.inhib))
        else $error("interrupt return not four cycles");

    ack_pulse_a: assert property (take |=>
        (irq_ack != '0) ##1 (irq_ack == '0))
        else $error("acknowledge not a single pulse");

    entry_cov: cover property (take ##5 vector_valid);
    wake_cov: cover property (take && sleeping);
    interrupt_return_instruction_cov: cover property (pc_load ##1 instr_done);
    predec_cov: cover property (ptr_req && ptr_mode == CSIC_PTR_PREDEC);
endmodule

// >>> design/csic_irq_arb.sv
`timescale 1ns/1ps
module csic_irq_arb (
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic [csic_pkg::CSIC_NSRC-1:0] irq_flag_set,
    input  wire logic [csic_pkg::CSIC_NSRC-1:0] irq_level,
    csic_irq_if.arb                             irq
);
    import csic_pkg::*;

    typedef struct packed {
        logic [CSIC_NSRC-1:0] flags;
    } csic_arb_s;

    csic_arb_s            r;
    csic_arb_s            next_r;
    logic [CSIC_NSRC-1:0] clr;
    logic [CSIC_NSRC-1:0] req;
    logic [CSIC_IDXW-1:0] idx;

    always_comb
    begin
        next_r = r;
        clr    = irq.clr_wr ? irq.clr_data : '0;
        if (irq.ack)
        begin
            clr = clr | csic_onehot(irq.ack_idx);
        end
        // set beats clear; flags hold while disabled
        next_r.flags = (r.flags & ~clr)
                     | (irq_flag_set & ~CSIC_LEVEL_MASK);
        // level sources ask only while present
        req = (r.flags | (irq_level & CSIC_LEVEL_MASK)) & irq.en;
        idx = '0;
        for (int i = CSIC_NSRC - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                idx = CSIC_IDXW'(i);
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign irq.req_any = |req;
    assign irq.req_idx = idx;
    assign irq.req     = req;
    assign irq.flags   = r.flags;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    prio_lowest_a: assert property (irq.req_any |->
        ((req & (csic_onehot(idx) - CSIC_NSRC'(1))) == '0))
        else $error("a lower index request was passed over");

    flag_hold_a: assert property ((!irq.clr_wr && !irq.ack) |=>
        ((r.flags & $past(r.flags)) == $past(r.flags)))
        else $error("pending flag lost without a clear");

    level_noflag_a: assert property (
        (r.flags & CSIC_LEVEL_MASK) == '0)
        else $error("level source latched a flag");
endmodule

// >>> design/csic_irq_if.sv
`timescale 1ns/1ps
interface csic_irq_if;
    logic [csic_pkg::CSIC_NSRC-1:0] en;
    logic                           clr_wr;
    logic [csic_pkg::CSIC_NSRC-1:0] clr_data;
    logic                           ack;
    logic [csic_pkg::CSIC_IDXW-1:0] ack_idx;
    logic                           req_any;
    logic [csic_pkg::CSIC_IDXW-1:0] req_idx;
    logic [csic_pkg::CSIC_NSRC-1:0] req;
    logic [csic_pkg::CSIC_NSRC-1:0] flags;

    modport arb (
        input  en,
        input  clr_wr,
        input  clr_data,
        input  ack,
        input  ack_idx,
        output req_any,
        output req_idx,
        output req,
        output flags
    );

    modport core (
        output en,
        output clr_wr,
        output clr_data,
        output ack,
        output ack_idx,
        input  req_any,
        input  req_idx,
        input  req,
        input  flags
    );
endinterface

// >>> design/csic_pkg.sv
package csic_pkg;

    // interrupt sources, lowest index ranks highest
    localparam int         CSIC_NSRC       = 4;
    localparam int         CSIC_IDXW       = 2;
    // sources with a level-type condition, no flag
    localparam logic [3:0] CSIC_LEVEL_MASK = 4'h8;

    // i/o space offsets of the block's registers
    localparam logic [5:0] CSIC_IO_SPL     = 6'h2D;
    localparam logic [5:0] CSIC_IO_SPH     = 6'h2E;
    localparam logic [5:0] CSIC_IO_FLAGS   = 6'h2F;

    // reset values and fixed fields
    localparam logic [7:0] CSIC_SPL_RESET  = 8'h00;
    localparam logic [7:0] CSIC_SPH_VALUE  = 8'h00;
    localparam logic [7:0] CSIC_FLAGS_RESET = 8'h00;
    localparam int         CSIC_GIE_BIT    = 7;

    // pointer bytes start at general register 26
    localparam logic [4:0] CSIC_PTR_BASE   = 5'h1A;
    localparam logic [4:0] CSIC_PTR_TOP    = 5'h1F;

    // vectors: reset at zero, source i at base plus i
    localparam logic [9:0] CSIC_RESET_VEC  = 10'h000;
    localparam logic [9:0] CSIC_VEC_BASE   = 10'h001;

    // sequence lengths in core clock cycles
    localparam int         CSIC_ENTRY_CYC  = 4;
    localparam int         CSIC_WAKE_CYC   = 4;
    localparam int         CSIC_INTERRUPT_RETURN_INSTRUCTION_CYC   = 4;
    localparam logic [3:0] CSIC_ENTRY_LAST = 4'(CSIC_ENTRY_CYC - 1);
    localparam logic [3:0] CSIC_WAKE_LAST  =
        4'(CSIC_ENTRY_CYC + CSIC_WAKE_CYC - 1);
    localparam logic [3:0] CSIC_INTERRUPT_RETURN_INSTRUCTION_LAST  = 4'(CSIC_INTERRUPT_RETURN_INSTRUCTION_CYC - 1);

    typedef enum logic [1:0] {
        CSIC_IDLE,
        CSIC_ENTRY,
        CSIC_RETURN
    } csic_st_e;

    typedef enum logic [1:0] {
        CSIC_PTR_PLAIN,
        CSIC_PTR_DISP,
        CSIC_PTR_POSTINC,
        CSIC_PTR_PREDEC
    } csic_ptr_e;

    function automatic logic [CSIC_NSRC-1:0] csic_onehot(
        input logic [CSIC_IDXW-1:0] idx
    );
        csic_onehot = CSIC_NSRC'(1) << idx;
    endfunction

endpackage

// >>> verification/cpu_stack_and_interrupt_control_tb.sv
`timescale 1ns/1ps
module cpu_stack_and_interrupt_control_tb;
    import csic_pkg::*;
    logic clk_sys = 0, rst = 1, instr_done = 0, op_push = 0, op_pop = 0;
    logic op_call = 0, op_ret = 0, op_interrupt_return_instruction = 0, op_sei = 0, op_cli = 0;
    logic sleeping = 0, wake_ready = 0, alu_flags_wr = 0, io_wr_en = 0;
    logic io_rd_en = 0, gpr_wr_en = 0, ptr_req = 0, flag_clr_wr = 0;
    logic seq_hold, wake_req, vector_valid, stack_we, stack_rd_en;
    logic pc_load, gie;
    logic [9:0] pc_in = 10'h2A5, vector_addr, pc_out;
    logic [6:0] alu_flags = 0;
    logic [5:0] io_addr = 0, ptr_disp = 6'h05;
    logic [7:0] io_wr_data = 0, gpr_wr_data = 0, io_rd_data, gpr_rd_data;
    logic [7:0] stack_wr_data, stack_rd_data;
    logic [4:0] gpr_wr_addr = 0, gpr_rd_addr = 0;
    logic [1:0] ptr_sel = 0;
    logic [15:0] data_addr, stack_addr;
    logic [3:0] irq_flag_set = 0, irq_level = 0, irq_enable = 0;
    logic [3:0] flag_clr_data = 0, irq_ack, ack;
    csic_ptr_e ptr_mode = CSIC_PTR_PLAIN;
    int n_fail = 0, compares = 0, n;
    csic_core dut (.*);
    csic_stack_mem mem_i (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int k = 1);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d);
        cyc();
        {io_wr_en, io_rd_en, io_addr, io_wr_data} <= {w, !w, a, d};
        cyc();
        {io_wr_en, io_rd_en} <= 2'h0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        io(0, a, 8'h00);
        @(negedge clk_sys);
        chk(16'(io_rd_data), 16'(e));
    endtask
    task automatic ops(input logic [3:0] v, input logic [7:0] e);
        cyc();
        {op_push, op_pop, op_call, op_ret} <= v;
        cyc();
        {op_push, op_pop, op_call, op_ret} <= 4'h0;
        rd(CSIC_IO_SPL, e);
    endtask
    task automatic fl(input logic [3:0] f);
        cyc();
        irq_flag_set <= f;
        cyc();
        irq_flag_set <= 4'h0;
    endtask
    task automatic bnd(input logic s = 0, input logic c = 0);
        cyc();
        {instr_done, op_sei, op_cli} <= {1'b1, s, c};
        cyc();
        {instr_done, op_sei, op_cli} <= 3'h0;
    endtask
    task automatic ptr(input csic_ptr_e m, input logic [15:0] e);
        cyc();
        ptr_req  <= 1'b1;
        ptr_mode <= m;
        cyc();
        ptr_req <= 1'b0;
        @(negedge clk_sys);
        chk(data_addr, e);
    endtask
    task automatic none();
        @(negedge clk_sys);
        chk(16'(seq_hold), 16'h0000);
    endtask
    task automatic wt();
        ack = 4'h0;
        for (n = 1; n <= 12; n++)
        begin
            @(negedge clk_sys);
            ack |= irq_ack;
            if (vector_valid | pc_load)
                return;
        end
        n_fail++;
        tally_and_finish();
    endtask
    initial
    begin
        cyc(20);
        rst <= 0;
        rd(CSIC_IO_SPL, CSIC_SPL_RESET);
        io(1, CSIC_IO_SPH, 8'hFF);
        rd(CSIC_IO_SPH, 8'h00);
        io(1, CSIC_IO_SPL, 8'hC0);
        ops(4'h8, 8'hBF);
        ops(4'h2, 8'hBD);
        ops(4'h4, 8'hBE);
        ops(4'h1, 8'hC0);
        cyc();
        {gpr_wr_en, gpr_wr_addr, gpr_wr_data} <= {1'b1, CSIC_PTR_BASE, 8'h10};
        cyc();
        {gpr_wr_en, ptr_req} <= 2'h1;
        ptr_mode <= CSIC_PTR_POSTINC;
        cyc();
        {ptr_req, gpr_rd_addr} <= {1'b0, CSIC_PTR_BASE};
        @(negedge clk_sys);
        chk(data_addr, 16'h0010);
        @(negedge clk_sys);
        chk(16'(gpr_rd_data), 16'h0011);
        ptr(CSIC_PTR_DISP, 16'h0016);
        ptr(CSIC_PTR_PREDEC, 16'h0010);
        io(1, CSIC_IO_FLAGS, 8'h80);
        fl(4'h3);
        bnd();
        none();
        cyc();
        irq_enable <= 4'h7;
        bnd();
        wt();
        chk(16'(n), 16'h0005);
        chk(16'(vector_addr), 16'h0001);
        chk(16'(ack), 16'h0001);
        chk(16'(gie), 16'h0000);
        rd(CSIC_IO_SPL, 8'hBE);
        cyc();
        {alu_flags_wr, alu_flags} <= {1'b1, 7'h55};
        cyc();
        alu_flags_wr <= 1'b0;
        cyc();
        op_interrupt_return_instruction <= 1;
        cyc();
        op_interrupt_return_instruction <= 0;
        wt();
        chk(16'(n), 16'h0005);
        chk(16'(pc_out), 16'h02A5);
        chk(16'(gie), 16'h0001);
        bnd();
        none();
        rd(CSIC_IO_FLAGS, 8'hD5);
        bnd();
        wt();
        chk(16'(vector_addr), 16'h0002);
        fl(4'h1);
        io(1, CSIC_IO_FLAGS, 8'h80);
        bnd(0, 1);
        none();
        bnd(1, 0);
        none();
        bnd();
        none();
        bnd();
        wt();
        chk(16'(vector_addr), 16'h0001);
        cyc();
        irq_level <= 4'h8;
        cyc();
        {irq_level, irq_enable} <= 8'h0F;
        io(1, CSIC_IO_FLAGS, 8'h80);
        bnd();
        none();
        fl(4'h2);
        cyc();
        {flag_clr_wr, flag_clr_data} <= 5'h12;
        cyc();
        flag_clr_wr <= 1'b0;
        bnd();
        none();
        fl(4'h1);
        io(1, CSIC_IO_FLAGS, 8'h80);
        cyc();
        sleeping <= 1'b1;
        cyc();
        @(negedge clk_sys);
        chk(16'(wake_req), 16'h0001);
        cyc();
        wake_ready <= 1'b1;
        wt();
        chk(16'(n), 16'h000A);
        tally_and_finish();
    end
endmodule

// >>> verification/csic_stack_mem.sv
`timescale 1ns/1ps
// far side: data sram holding the stack bytes
module csic_stack_mem (
    input  wire logic        clk_sys,
    input  wire logic        stack_we,
    input  wire logic        stack_rd_en,
    input  wire logic [15:0] stack_addr,
    input  wire logic [7:0]  stack_wr_data,
    output logic      [7:0]  stack_rd_data
);
    logic [7:0] mem [256];
    initial stack_rd_data = 8'h00;
    // read answers one cycle later, otherwise a toggling pattern
    always @(posedge clk_sys)
    begin
        if (stack_we)
            mem[stack_addr[7:0]] <= stack_wr_data;
        stack_rd_data <= stack_rd_en ? mem[stack_addr[7:0]] : ~stack_rd_data;
    end
endmodule
